/* design/eut_trigger_trace.sv */
// emulator break, trigger, trace store, image store and analyzer outputs
`timescale 1ns/10ps
`default_nettype none

module eut_trigger_trace
  import eut_pkg::*;
#(
  parameter int          TRACE_DEPTH     = EUT_TRACE_DEPTH,
  parameter int unsigned LED_HALF_CYCLES = EUT_LED_HALF_CYCLES
) (
  input  wire logic                      clock,
  input  wire logic                      arst_n,
  input  wire logic                      ce,
  input  wire eut_avs_req_type           avsReq,
  output var  eut_avs_rsp_type           avsRsp,
  input  wire logic                      coreClk,
  input  wire logic [EUT_BUS_W-1:0]      instrAddr,
  input  wire logic [EUT_BUS_W-1:0]      dataBus,
  input  wire eut_marks_type             marks,
  input  wire logic [EUT_LINES-1:0]      trigIn,
  input  wire logic [EUT_IMG_SLOTS-1:0]  nvImageMap,
  output logic                           haltOut,
  output logic [EUT_LINES-1:0]           trigOut,
  output logic [EUT_BUS_W-1:0]           laAddr,
  output logic [EUT_BUS_W-1:0]           laData,
  output logic                           emulated_core_clock_out,
  output logic                           greenLed,
  output logic                           nvCommit,
  output logic [2:0]                     nvCommitSlot,
  output logic [2:0]                     deviceSel,
  output logic                           deviceValid
);

  localparam int PTR_W = $clog2(TRACE_DEPTH);

  if (TRACE_DEPTH != (1 << PTR_W) || TRACE_DEPTH < 2) begin : g_chk_depth
    $error("trace depth must be a power of two");
  end
  if (LED_HALF_CYCLES < 1) begin : g_chk_led
    $error("indicator half period must be at least one cycle");
  end

  typedef struct packed {
    logic                     waitReg;
    logic [31:0]              rdDataReg;
    logic                     traceEnReg;
    logic [EUT_LINES-1:0]     outMaskReg;
    logic [EUT_LINES-1:0]     inMaskReg;
    logic [EUT_LINES-1:0]     trMaskReg;
    eut_halt_type             haltReg;
    eut_cause_type            causeReg;
    logic                     traceActiveReg;
    logic [PTR_W-1:0]         wrPtrReg;
    logic                     wrappedReg;
    logic [PTR_W-1:0]         rdIdxReg;
    logic                     clkPrevReg;
    logic                     coreClkOutReg;
    logic [EUT_LINES-1:0]     trigPrevReg;
    logic [EUT_LINES-1:0]     trigOutReg;
    logic [EUT_BUS_W-1:0]     laAddrReg;
    logic [EUT_BUS_W-1:0]     laDataReg;
    logic [31:0]              stampReg;
    logic                     dlBusyReg;
    logic [2:0]               dlSlotReg;
    logic [31:0]              ledCntReg;
    logic                     ledReg;
    logic [EUT_IMG_SLOTS-1:0] activeMapReg;
    logic                     mapLoadedReg;
    logic [2:0]               devSelReg;
    logic                     devValidReg;
    logic                     nvCommitReg;
    logic                     haltOutReg;
  } eut_state_type;

  localparam eut_state_type STATE_RST = '{
    waitReg:        1'b1,
    rdDataReg:      32'h0000_0000,
    traceEnReg:     EUT_TRACEEN_RST,
    outMaskReg:     EUT_MASK_RST,
    inMaskReg:      EUT_MASK_RST,
    trMaskReg:      EUT_MASK_RST,
    haltReg:        EUT_RUN,
    causeReg:       EUT_CAUSE_NONE,
    traceActiveReg: 1'b0,
    wrPtrReg:       '0,
    wrappedReg:     1'b0,
    rdIdxReg:       '0,
    clkPrevReg:     1'b0,
    coreClkOutReg:  1'b0,
    trigPrevReg:    5'h00,
    trigOutReg:     5'h00,
    laAddrReg:      16'h0000,
    laDataReg:      16'h0000,
    stampReg:       32'h0000_0000,
    dlBusyReg:      1'b0,
    dlSlotReg:      3'h0,
    ledCntReg:      32'h0000_0000,
    ledReg:         1'b1,
    activeMapReg:   6'h00,
    mapLoadedReg:   1'b0,
    devSelReg:      3'h0,
    devValidReg:    1'b0,
    nvCommitReg:    1'b0,
    haltOutReg:     1'b0
  };

  eut_state_type st_reg;
  eut_state_type st_next;
  logic [1:0]    rstPipe_reg;
  logic          rstSync_n;

  eut_entry_type traceMem [TRACE_DEPTH];
  eut_entry_type memEntry;
  eut_entry_type rdEntry;
  logic          memWe;

  logic [EUT_LINES-1:0] trigRise;
  logic                 coreEdge;
  logic                 execStep;
  logic                 traceNow;
  logic                 busWrite;
  logic                 busRead;
  logic [31:0]          rdMux;
  logic [31:0]          wrData;
  logic [2:0]           slotReq;

  // reset release through two flip-flops
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rstPipe_reg <= 2'b00;
    end else begin
      rstPipe_reg <= {rstPipe_reg[0], 1'b1};
    end
  end
  assign rstSync_n = rstPipe_reg[1];

  // edges are seen on every fast clock, independent of trace sampling
  for (genvar i = 0; i < EUT_LINES; i++) begin : g_rise
    assign trigRise[i] = trigIn[i] & ~st_reg.trigPrevReg[i]
                         & st_reg.inMaskReg[i];
  end

  assign rdEntry = traceMem[st_reg.rdIdxReg];

  function automatic logic [31:0] be_merge(
    input logic [31:0] oldVal,
    input logic [31:0] newVal,
    input logic [3:0]  be
  );
    logic [31:0] res;
    res = oldVal;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = newVal[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // register read view; unmapped offsets read zero
  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (avsReq.address)
      EUT_CTRL_OFS:    rdMux[EUT_CTRL_TRACEEN] = st_reg.traceEnReg;
      EUT_OUTMASK_OFS: rdMux[EUT_LINES-1:0] = st_reg.outMaskReg;
      EUT_INMASK_OFS:  rdMux[EUT_LINES-1:0] = st_reg.inMaskReg;
      EUT_TRMASK_OFS:  rdMux[EUT_LINES-1:0] = st_reg.trMaskReg;
      EUT_STATUS_OFS:  rdMux[5:0] = {st_reg.wrappedReg,
                                     st_reg.traceActiveReg,
                                     st_reg.causeReg,
                                     st_reg.haltReg};
      EUT_WRPTR_OFS:   rdMux[PTR_W-1:0] = st_reg.wrPtrReg;
      EUT_RDIDX_OFS:   rdMux[PTR_W-1:0] = st_reg.rdIdxReg;
      EUT_TRD0_OFS:    rdMux = rdEntry[31:0];
      EUT_TRD1_OFS:    rdMux = rdEntry[63:32];
      EUT_TRD2_OFS:    rdMux = rdEntry[95:64];
      EUT_IMGCTRL_OFS: rdMux[10:8] = st_reg.dlSlotReg;
      EUT_IMGSTAT_OFS: rdMux[6:0] = {st_reg.dlBusyReg,
                                     st_reg.activeMapReg};
      EUT_DEVSEL_OFS:  rdMux[3:0] = {st_reg.devValidReg,
                                     st_reg.devSelReg};
      default:         rdMux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    st_next  = st_reg;
    memWe    = 1'b0;
    memEntry = '0;
    busRead  = avsReq.read & st_reg.waitReg;
    busWrite = avsReq.write & ~st_reg.waitReg;
    wrData   = be_merge(rdMux, avsReq.writedata, avsReq.byteenable);
    slotReq  = wrData[EUT_IMG_SLOT_LSB +: 3];
    coreEdge = coreClk & ~st_reg.clkPrevReg;
    execStep = coreEdge && st_reg.haltReg != EUT_HALTED
               && !(marks.breakMark
                    && st_reg.haltReg == EUT_RUN);
    traceNow = st_reg.traceActiveReg;

    // bus slave: answer one cycle after the request, complete next edge
    st_next.waitReg = ~((avsReq.read | avsReq.write) & st_reg.waitReg);
    if (busRead) begin
      st_next.rdDataReg = rdMux;
    end
    st_next.nvCommitReg = 1'b0;

    if (!st_reg.mapLoadedReg) begin
      st_next.activeMapReg = nvImageMap;
      st_next.mapLoadedReg = 1'b1;
    end

    if (busWrite) begin
      unique case (avsReq.address)
        EUT_CTRL_OFS: begin
          st_next.traceEnReg = wrData[EUT_CTRL_TRACEEN];
          if (wrData[EUT_CTRL_RESUME]
              && st_reg.haltReg == EUT_HALTED) begin
            st_next.haltReg  = EUT_RESUME;
            st_next.causeReg = EUT_CAUSE_NONE;
          end
        end
        EUT_OUTMASK_OFS: st_next.outMaskReg = wrData[EUT_LINES-1:0];
        EUT_INMASK_OFS:  st_next.inMaskReg  = wrData[EUT_LINES-1:0];
        EUT_TRMASK_OFS:  st_next.trMaskReg  = wrData[EUT_LINES-1:0];
        EUT_WRPTR_OFS: begin
          st_next.wrPtrReg   = '0;
          st_next.wrappedReg = 1'b0;
        end
        EUT_RDIDX_OFS: st_next.rdIdxReg = wrData[PTR_W-1:0];
        EUT_IMGCTRL_OFS: begin
          if (wrData[EUT_IMG_START] && !st_reg.dlBusyReg
              && int'(slotReq) < EUT_IMG_SLOTS) begin
            st_next.dlBusyReg = 1'b1;
            st_next.dlSlotReg = slotReq;
          end else if (wrData[EUT_IMG_DONE] && st_reg.dlBusyReg) begin
            st_next.dlBusyReg   = 1'b0;
            st_next.nvCommitReg = 1'b1;
          end
        end
        EUT_DEVSEL_OFS: begin
          if (int'(wrData[2:0]) < EUT_IMG_SLOTS
              && st_reg.activeMapReg[wrData[2:0]]) begin
            st_next.devSelReg   = wrData[2:0];
            st_next.devValidReg = 1'b1;
          end else begin
            st_next.devValidReg = 1'b0;
          end
        end
        default: st_next.waitReg = ~((avsReq.read | avsReq.write)
                                     & st_reg.waitReg);
      endcase
    end

    // core cycle: analyzer view, stamp, trigger outputs, trace
    st_next.clkPrevReg    = coreClk;
    st_next.coreClkOutReg = coreClk;
    st_next.trigPrevReg   = trigIn;
    if (coreEdge) begin
      st_next.laAddrReg  = instrAddr;
      st_next.laDataReg  = dataBus;
      st_next.stampReg   = st_reg.stampReg + 32'h0000_0001;
      st_next.trigOutReg = 5'h00;
    end
    if (execStep) begin
      st_next.trigOutReg = marks.trigSel & st_reg.outMaskReg;
      if (marks.traceOnMark) begin
        traceNow = 1'b1;
      end else if (marks.traceOffMark) begin
        traceNow = 1'b0;
      end
      st_next.traceActiveReg = traceNow;
      if (traceNow && st_reg.traceEnReg) begin
        memWe            = 1'b1;
        memEntry.addr    = instrAddr;
        memEntry.data    = dataBus;
        memEntry.ext     = trigIn & st_reg.trMaskReg;
        memEntry.trigOut = marks.trigSel & st_reg.outMaskReg;
        memEntry.stamp   = st_reg.stampReg;
        st_next.wrPtrReg = st_reg.wrPtrReg + PTR_W'(1);
        if (&st_reg.wrPtrReg) begin
          st_next.wrappedReg = 1'b1;
        end
      end
    end

    // halt sequencing; a new halt wins over a resume in the same cycle
    unique case (st_reg.haltReg)
      EUT_RUN: begin
        if (coreEdge && marks.breakMark) begin
          st_next.haltReg  = EUT_HALTED;
          st_next.causeReg = EUT_CAUSE_BREAK;
        end
      end
      EUT_HALTED: begin
      end
      EUT_RESUME: begin
        if (coreEdge) begin
          st_next.haltReg = EUT_RUN;
        end
      end
      default: st_next.haltReg = EUT_RUN;
    endcase
    if (|trigRise) begin
      st_next.haltReg  = EUT_HALTED;
      st_next.causeReg = EUT_CAUSE_TRIG;
    end
    st_next.haltOutReg = (st_next.haltReg == EUT_HALTED);

    // indicator: steady when idle, flashing while downloading
    if (st_reg.dlBusyReg) begin
      if (st_reg.ledCntReg >= LED_HALF_CYCLES - 1) begin
        st_next.ledCntReg = 32'h0000_0000;
        st_next.ledReg    = ~st_reg.ledReg;
      end else begin
        st_next.ledCntReg = st_reg.ledCntReg + 32'h0000_0001;
      end
    end else begin
      st_next.ledCntReg = 32'h0000_0000;
      st_next.ledReg    = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      st_reg <= STATE_RST;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // trace store has no reset; only written entries are meaningful
  always_ff @(posedge clock) begin
    if (ce && memWe) begin
      traceMem[st_reg.wrPtrReg] <= memEntry;
    end
  end

  assign avsRsp.readdata          = st_reg.rdDataReg;
  assign avsRsp.waitrequest       = st_reg.waitReg;
  assign haltOut                  = st_reg.haltOutReg;
  assign trigOut                  = st_reg.trigOutReg;
  assign laAddr                   = st_reg.laAddrReg;
  assign laData                   = st_reg.laDataReg;
  assign emulated_core_clock_out  = st_reg.coreClkOutReg;
  assign greenLed                 = st_reg.ledReg;
  assign nvCommit                 = st_reg.nvCommitReg;
  assign nvCommitSlot             = st_reg.dlSlotReg;
  assign deviceSel                = st_reg.devSelReg;
  assign deviceValid              = st_reg.devValidReg;

endmodule // eut_trigger_trace

`default_nettype wire

/* design/eut_pkg.sv */
// constants and carrier types of the emulator trigger and trace block
package eut_pkg;
  localparam int EUT_LINES       = 5;
  localparam int EUT_TRACE_DEPTH = 32768;
  localparam int EUT_ENTRY_W     = 96;
  localparam int EUT_IMG_SLOTS   = 6;
  localparam int EUT_BUS_W       = 16;
  localparam int EUT_ADDR_W      = 6;
  // register byte offsets
  localparam logic [5:0] EUT_CTRL_OFS    = 6'h00;
  localparam logic [5:0] EUT_OUTMASK_OFS = 6'h04;
  localparam logic [5:0] EUT_INMASK_OFS  = 6'h08;
  localparam logic [5:0] EUT_TRMASK_OFS  = 6'h0c;
  localparam logic [5:0] EUT_STATUS_OFS  = 6'h10;
  localparam logic [5:0] EUT_WRPTR_OFS   = 6'h14;
  localparam logic [5:0] EUT_RDIDX_OFS   = 6'h18;
  localparam logic [5:0] EUT_TRD0_OFS    = 6'h1c;
  localparam logic [5:0] EUT_TRD1_OFS    = 6'h20;
  localparam logic [5:0] EUT_TRD2_OFS    = 6'h24;
  localparam logic [5:0] EUT_IMGCTRL_OFS = 6'h28;
  localparam logic [5:0] EUT_IMGSTAT_OFS = 6'h2c;
  localparam logic [5:0] EUT_DEVSEL_OFS  = 6'h30;
  // field positions
  localparam int EUT_CTRL_RESUME  = 0;
  localparam int EUT_CTRL_TRACEEN = 1;
  localparam int EUT_IMG_START    = 0;
  localparam int EUT_IMG_DONE     = 1;
  localparam int EUT_IMG_SLOT_LSB = 8;
  localparam int EUT_DEV_VALID    = 3;
  // reset values
  localparam logic [4:0] EUT_MASK_RST    = 5'h00;
  localparam logic       EUT_TRACEEN_RST = 1'b1;
  // timing
  localparam int EUT_CLK_MHZ     = 200;
  localparam int EUT_LED_HALF_MS = 250;
  localparam int EUT_LED_HALF_CYCLES = EUT_LED_HALF_MS * 1000 * EUT_CLK_MHZ;

  typedef struct packed {
    logic [21:0] zero;
    logic [31:0] stamp;
    logic [4:0]  trigOut;
    logic [4:0]  ext;
    logic [15:0] data;
    logic [15:0] addr;
  } eut_entry_type;

  typedef struct packed {
    logic       breakMark;
    logic       traceOnMark;
    logic       traceOffMark;
    logic [4:0] trigSel;
  } eut_marks_type;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [5:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } eut_avs_req_type;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } eut_avs_rsp_type;

  typedef enum logic [1:0] {
    EUT_RUN    = 2'b00,
    EUT_HALTED = 2'b01,
    EUT_RESUME = 2'b11
  } eut_halt_type;

  typedef enum logic [1:0] {
    EUT_CAUSE_NONE  = 2'b00,
    EUT_CAUSE_BREAK = 2'b01,
    EUT_CAUSE_TRIG  = 2'b10
  } eut_cause_type;
endpackage

/* testbench/eut_trigger_trace_props.sv */
// port assertions for the trigger and trace block
`timescale 1ns/10ps
`default_nettype none
module eut_trigger_trace_props
  import eut_pkg::*;
(
  input wire logic                 clock,
  input wire logic                 arst_n,
  input wire eut_avs_req_type      avsReq,
  input wire eut_avs_rsp_type      avsRsp,
  input wire logic                 coreClk,
  input wire logic [EUT_BUS_W-1:0] instrAddr,
  input wire eut_marks_type        marks,
  input wire logic [EUT_LINES-1:0] trigIn,
  input wire logic                 haltOut,
  input wire logic [EUT_LINES-1:0] trigOut,
  input wire logic [EUT_BUS_W-1:0] laAddr,
  input wire logic                 emulated_core_clock_out,
  input wire logic                 nvCommit,
  input wire logic [2:0]           deviceSel,
  input wire logic                 deviceValid
);
  logic [1:0] upReg;
  logic       cPrev;
  logic       resSh;
  logic [4:0] tPrev;
  logic [4:0] outSh;
  logic [4:0] inSh;
  wire logic wrDone = avsReq.write && !avsRsp.waitrequest;
  wire logic rise = coreClk && !cPrev;
  wire logic exec = rise && !haltOut && !marks.breakMark;
  // shadows of the output and input masks and of a pending resume, taken from completed bus writes
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      upReg <= 2'h0;
      cPrev <= 1'b0;
      resSh <= 1'b0;
      tPrev <= 5'h00;
      outSh <= 5'h00;
      inSh  <= 5'h00;
    end else begin
      if (upReg != 2'h3) upReg <= upReg + 2'h1;
      cPrev <= coreClk;
      tPrev <= trigIn;
      if (wrDone && avsReq.address == EUT_OUTMASK_OFS)
        outSh <= avsReq.writedata[4:0];
      if (wrDone && avsReq.address == EUT_INMASK_OFS)
        inSh <= avsReq.writedata[4:0];
      if (wrDone && avsReq.address == EUT_CTRL_OFS &&
          avsReq.writedata[0] && haltOut) resSh <= 1'b1;
      else if (rise) resSh <= 1'b0;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n || upReg != 2'h3);
  wait_one_a: assert property (
    !avsRsp.waitrequest |=> avsRsp.waitrequest)
    else $error("waitrequest low for more than one cycle");
  out_masked_a: assert property (
    (trigOut & ~outSh) == 5'h00) else $error("masked trigger out high");
  trig_exact_a: assert property (
    exec |-> ##2 trigOut == (marks.trigSel & outSh))
    else $error("trigger out differs from selection");
  la_capture_a: assert property (
    exec |-> ##2 laAddr == instrAddr) else $error("analyzer address wrong");
  clk_echo_a: assert property (
    emulated_core_clock_out == $past(coreClk))
    else $error("core clock echo wrong");
  brk_halt_a: assert property (
    rise && marks.breakMark && !haltOut && !resSh
    |-> ##2 haltOut && trigOut == 5'h00)
    else $error("no halt at breakpoint");
  in_break_a: assert property (
    |(trigIn & ~tPrev & inSh) |-> ##[1:2] haltOut)
    else $error("enabled input edge did not halt");
  commit_pulse_a: assert property (
    nvCommit |=> !nvCommit) else $error("commit pulse too long");
  dev_valid_a: assert property (
    deviceValid |-> deviceSel < 3'h6) else $error("valid on absent slot");
  trig_c: cover property (exec && marks.trigSel != 5'h00);
  halt_c: cover property ($rose(haltOut));
  commit_c: cover property (nvCommit);
endmodule // eut_trigger_trace_props
bind eut_trigger_trace eut_trigger_trace_props eut_trigger_trace_props_inst (
  .clock(clock), .arst_n(arst_n), .avsReq(avsReq), .avsRsp(avsRsp),
  .coreClk(coreClk), .instrAddr(instrAddr), .marks(marks), .trigIn(trigIn),
  .haltOut(haltOut), .trigOut(trigOut), .laAddr(laAddr),
  .emulated_core_clock_out(emulated_core_clock_out), .nvCommit(nvCommit),
  .deviceSel(deviceSel), .deviceValid(deviceValid));
`default_nettype wire

/* testbench/eut_core_model.sv */
// emulated core: divided clock, program counter and instruction flags
`timescale 1ns/10ps
`default_nettype none
module eut_core_model
  import eut_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          arst_n,
  input  wire logic          run,
  input  wire logic          halt,
  input  wire eut_marks_type marksIn,
  output logic               coreClk,
  output logic [15:0]        instrAddr,
  output logic [15:0]        dataBus,
  output eut_marks_type      marks
);
  logic [2:0] cnt;
  logic       skip;
  // clock stands low between runs; buses change only while it is low
  assign coreClk = cnt[2];
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 3'h0;
      skip <= 1'b0;
      instrAddr <= 16'h0000;
      dataBus <= 16'h0000;
      marks <= '0;
    end else begin
      if (run || cnt != 3'h0) cnt <= cnt + 3'h1;
      if (cnt == 3'h7) skip <= halt;
      // a halted instruction is presented again
      if (cnt == 3'h1 && !skip) begin
        instrAddr <= instrAddr + 16'h0001;
        dataBus <= ~instrAddr;
        marks <= marksIn;
      end
    end
  end
endmodule // eut_core_model
`default_nettype wire

/* testbench/eut_trigger_trace_tb.sv */
// self-checking bench of the trigger and trace block
`timescale 1ns/10ps
`default_nettype none
module eut_trigger_trace_tb;
  import eut_pkg::*;
  logic clock, arst_n, coreClk, run, haltOut, greenLed, nvCommit, devValid;
  logic clkEcho, ledPrev;
  eut_avs_req_type req;
  eut_avs_rsp_type rsp;
  eut_marks_type   marks, marksIn;
  logic [15:0] instrAddr, dataBus, laAddr, laData;
  logic [4:0]  trigIn, trigOut, t;
  logic [2:0]  commitSlot, devSel;
  logic [31:0] q;
  logic [5:0]  a, imgMap;
  int nMismatch, samplesChecked, ledN, commitN;
  eut_trigger_trace #(.TRACE_DEPTH(16), .LED_HALF_CYCLES(4))
  eut_trigger_trace_inst (.clock(clock), .arst_n(arst_n), .ce(1'b1),
    .avsReq(req), .avsRsp(rsp), .coreClk(coreClk), .instrAddr(instrAddr),
    .dataBus(dataBus), .marks(marks), .trigIn(trigIn),
    .nvImageMap(imgMap), .haltOut(haltOut), .trigOut(trigOut),
    .laAddr(laAddr), .laData(laData), .emulated_core_clock_out(clkEcho),
    .greenLed(greenLed), .nvCommit(nvCommit), .nvCommitSlot(commitSlot),
    .deviceSel(devSel), .deviceValid(devValid));
  eut_core_model eut_core_model_inst (.clock(clock), .arst_n(arst_n),
    .run(run), .halt(haltOut), .marksIn(marksIn), .coreClk(coreClk),
    .instrAddr(instrAddr), .dataBus(dataBus), .marks(marks));
  always #2.5 clock = ~clock;
  always @(posedge clock) begin
    if (greenLed !== ledPrev) ledN++;
    ledPrev = greenLed;
    if (nvCommit === 1'b1) commitN++;
  end
  task automatic completeRun;
    $display("checks %0d mismatches %0d", samplesChecked, nMismatch);
    if (nMismatch == 0 && samplesChecked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nMismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // waits for the answer as long as it takes; the watchdog ends a hang
  task automatic bus(input logic w, input logic [5:0] ad,
                     input logic [31:0] d);
    req <= '{read: !w, write: w, address: ad, writedata: d, byteenable: 4'hf};
    do begin
      @(posedge clock);
    end while (rsp.waitrequest !== 1'b0);
    q = rsp.readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [5:0] ad, input logic [31:0] d);
    bus(1'b1, ad, d);
  endtask
  task automatic rd(input logic [5:0] ad, input logic [31:0] m, e);
    bus(1'b0, ad, 32'h0);
    check(q & m, e);
  endtask
  // first instruction carries the flags, the rest are plain
  task automatic core(input int n, input logic [7:0] m);
    marksIn <= eut_marks_type'(m);
    run <= 1'b1;
    @(posedge coreClk);
    marksIn <= '0;
    repeat (3) @(posedge clock);
    t = trigOut;
    repeat (n - 1) @(posedge coreClk);
    run <= 1'b0;
    repeat (10) @(posedge clock);
  endtask
  initial begin
    #200000;
    nMismatch++;
    completeRun;
  end
  initial begin
    clock = 1'b0;
    arst_n = 1'b0;
    req = '0;
    imgMap = 6'h05;
    marksIn = '0;
    run = 1'b0;
    trigIn = 5'h00;
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    repeat (4) @(posedge clock);
    for (int i = 0; i < 3; i++) begin
      a = EUT_OUTMASK_OFS + 6'(4 * i);
      rd(a, 32'h1f, 32'h0);
      wr(a, 32'hffffffff);
      rd(a, 32'h1f, 32'h1f);
    end
    rd(6'h3c, 32'hffffffff, 32'h0);
    wr(EUT_OUTMASK_OFS, 32'h0);
    wr(EUT_INMASK_OFS, 32'h0);
    wr(EUT_TRMASK_OFS, 32'h05);
    trigIn <= 5'h1f;
    core(4, 8'h00);
    rd(EUT_STATUS_OFS, 32'h10, 32'h0);
    rd(EUT_WRPTR_OFS, 32'h7fff, 32'h0);
    core(3, 8'h40);
    rd(EUT_WRPTR_OFS, 32'h7fff, 32'h3);
    core(2, 8'h20);
    rd(EUT_WRPTR_OFS, 32'h7fff, 32'h3);
    wr(EUT_RDIDX_OFS, 32'h0);
    rd(EUT_TRD1_OFS, 32'h1f, 32'h05);
    rd(EUT_TRD2_OFS, 32'hfffffc00, 32'h0);
    wr(EUT_CTRL_OFS, 32'h0);
    core(2, 8'h40);
    rd(EUT_WRPTR_OFS, 32'h7fff, 32'h3);
    wr(EUT_CTRL_OFS, 32'h2);
    wr(EUT_WRPTR_OFS, 32'h0);
    core(17, 8'h00);
    rd(EUT_WRPTR_OFS, 32'h7fff, 32'h1);
    rd(EUT_STATUS_OFS, 32'h20, 32'h20);
    trigIn <= 5'h00;
    for (int i = 0; i < 2; i++) begin
      wr(EUT_OUTMASK_OFS, i ? 32'h15 : 32'h0a);
      core(2, 8'h1f);
      check(32'(t), i ? 32'h15 : 32'h0a);
    end
    for (int i = 0; i < 2; i++) begin
      bus(1'b0, EUT_WRPTR_OFS, 32'h0);
      a = q[5:0];
      core(1, 8'h9f);
      check(32'(haltOut), 32'h1);
      check(32'(t), 32'h0);
      rd(EUT_STATUS_OFS, 32'hf, 32'h5);
      rd(EUT_WRPTR_OFS, 32'h7fff, 32'(a));
      wr(EUT_CTRL_OFS, 32'h3);
      rd(EUT_STATUS_OFS, 32'h3, 32'h3);
      core(1, 8'h00);
      check(32'(t), 32'h15);
      rd(EUT_WRPTR_OFS, 32'h7fff, 32'((a + 6'h1) & 6'hf));
    end
    wr(EUT_INMASK_OFS, 32'h0c);
    for (int i = 0; i < 5; i++) begin
      trigIn <= 5'(1 << i);
      @(posedge clock);
      trigIn <= 5'h00;
      repeat (4) @(posedge clock);
      check(32'(haltOut), 32'((5'h0c >> i) & 5'h1));
      if (haltOut === 1'b1) rd(EUT_STATUS_OFS, 32'hc, 32'h8);
      wr(EUT_CTRL_OFS, 32'h3);
    end
    core(1, 8'h00);
    check(32'(laAddr), 32'(instrAddr));
    check(32'(laData), 32'(dataBus));
    rd(EUT_IMGSTAT_OFS, 32'h3f, 32'h05);
    for (int s = 0; s < 8; s++) begin
      wr(EUT_DEVSEL_OFS, 32'(s));
      rd(EUT_DEVSEL_OFS, 32'h8, (s == 0 || s == 2) ? 32'h8 : 32'h0);
      check(32'(devValid), (s == 0 || s == 2) ? 32'h1 : 32'h0);
    end
    ledN = 0;
    // the stored images change now; the active set must wait for reset
    imgMap <= 6'h3f;
    wr(EUT_IMGCTRL_OFS, 32'h101);
    repeat (20) @(posedge clock);
    check(32'(ledN >= 4), 32'h1);
    rd(EUT_IMGSTAT_OFS, 32'h40, 32'h40);
    wr(EUT_IMGCTRL_OFS, 32'h102);
    repeat (4) @(posedge clock);
    check(32'(commitN), 32'h1);
    check(32'(commitSlot), 32'h1);
    check(32'(greenLed), 32'h1);
    rd(EUT_IMGSTAT_OFS, 32'h3f, 32'h05);
    wr(EUT_IMGCTRL_OFS, 32'h701);
    rd(EUT_IMGSTAT_OFS, 32'h40, 32'h0);
    rd(EUT_IMGCTRL_OFS, 32'h700, 32'h100);
    // power cycle: the downloaded set becomes active
    arst_n <= 1'b0;
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    repeat (4) @(posedge clock);
    check(32'(haltOut), 32'h0);
    rd(EUT_IMGSTAT_OFS, 32'h3f, 32'h3f);
    rd(EUT_STATUS_OFS, 32'h3f, 32'h0);
    completeRun;
  end
endmodule // eut_trigger_trace_tb
`default_nettype wire
